/* design/aof_top.sv */
// Contract
// - enabling internal termination doubles the output driver current.
// - overflow flag is high exactly when input is over or under range.
// - overflow travels through the same pipeline stages as its data.
// - full rate has one overflow per channel; DDR shares one overflow output.
// - full rate data changes on true clock falling edge; receiver uses rising.
// - DDR data changes on both true clock edges without phase shift.
// - forwarded clock lags data by 0, 45, 90 or 135 degrees.
// - invert bit flips both clock legs, giving 180 to 315 degrees.
// - reset coding is offset binary; a format bit selects two's complement.
// - zero input is 0x8000 offset binary; two's complement flips top bit.
// - over range gives max code, under range min code, both flagged.
// - randomizer XORs the LSB into other bits; LSB, flag, clock unchanged.
// - randomizer and alternate polarity enable independently.
// - constant patterns force flag and data all ones or all zeros.
// - alternating pattern toggles all ones and all zeros every sample.
// - checkerboard pattern alternates 1010..., complemented each sample.
// - test patterns bypass coding, randomizer and alternate polarity.
// - DDR sends two data bits per output, one per clock edge.
// - driver current defaults to 3.5 mA unless programmed.
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
module aof_top
  import aof_pkg::*;
#(
  parameter int ENC_DIV = ENC_DIV_DEFAULT
) (
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic I_CE,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic I_HREADY,
  input wire logic [31:0] I_HWDATA,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire logic I_ENC_CLK,
  input wire logic [15:0] I_CH1_CODE,
  input wire logic I_CH1_OVER,
  input wire logic I_CH1_UNDER,
  input wire logic [15:0] I_CH2_CODE,
  input wire logic I_CH2_OVER,
  input wire logic I_CH2_UNDER,
  output logic [15:0] O_CH1_SAMPLE_BITS,
  output logic [15:0] O_CH2_SAMPLE_BITS,
  output logic O_CHAN1_OVERFLOW_OUT,
  output logic O_CHAN2_OVERFLOW_OUT,
  output logic [7:0] O_CH1_DDR_BITS,
  output logic [7:0] O_CH2_DDR_BITS,
  output logic O_SHARED_OVERFLOW_OUT,
  output logic O_FWD_CLOCK_P,
  output logic O_FWD_CLOCK_N,
  output logic [1:0] O_OUT_MODE,
  output logic O_TERM_EN,
  output logic O_DRIVE_DOUBLE,
  output logic [2:0] O_DRIVE_CODE,
  output logic O_DCS_EN
);
  localparam int SMP_W = $bits(aof_sample_t);
  localparam int SW = 2 * SMP_W + 1;

  if (ENC_DIV < 4 || ENC_DIV > 65535) begin : g_bad_div
    $error("ENC_DIV must lie between 4 and 65535");
  end

  function automatic logic is_ddr(logic [1:0] m);
    return m != MODE_FULL;
  endfunction

  function automatic logic [7:0] pick(logic [15:0] d, logic odd);
    logic [7:0] r;
    for (int i = 0; i < HALF_W; i++) begin
      r[i] = d[2 * i + int'(odd)];
    end
    return r;
  endfunction

  function automatic logic [15:0] ph_shift(logic [15:0] per, logic [1:0] ph);
    logic [17:0] p;
    p = {2'b00, per} * {16'h0000, ph};
    return {1'b0, p[17:PH_SHIFT_BITS]};
  endfunction

  function automatic logic [31:0] reg_read(logic [7:0] a, aof_cfg_t c, aof_cfg_t act,
                                           logic [15:0] per);
    logic [31:0] r;
    r = '0;
    case (a)
      ADDR_CLK_CFG: begin
        r[CLK_PH_LSB +: 2] = c.phase;
        r[CLK_INV_BIT] = c.invert;
        r[CLK_DCS_BIT] = c.dcs;
      end
      ADDR_DRV_CFG: begin
        r[DRV_MODE_LSB +: 2] = c.mode;
        r[DRV_TERM_BIT] = c.term;
        r[DRV_CUR_LSB +: 3] = c.cur;
      end
      ADDR_FMT_CFG: begin
        r[FMT_TWOS_BIT] = c.twos;
        r[FMT_RND_BIT] = c.rnd_en;
        r[FMT_ABP_BIT] = c.abp;
        r[FMT_TP_LSB +: 3] = c.tp;
      end
      ADDR_STATUS: begin
        r[STAT_PER_LSB +: 16] = per;
        r[STAT_MODE_LSB +: 2] = act.mode;
        r[STAT_WARN_BIT] = (act.phase != 2'h0) && !act.dcs;
      end
      default: r = '0;
    endcase
    return r;
  endfunction

  // input synchronisers: encode clock and both channels' conversion results
  logic [SW-1:0] s1_r, s2_r;
  logic enc_d_r;
  logic bnd;
  aof_sample_t smp1, smp2;

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      s1_r <= '0;
      s2_r <= '0;
      enc_d_r <= 1'b0;
    end else if (I_CE) begin
      s1_r <= {I_ENC_CLK, I_CH2_OVER, I_CH2_UNDER, I_CH2_CODE,
               I_CH1_OVER, I_CH1_UNDER, I_CH1_CODE};
      s2_r <= s1_r;
      enc_d_r <= s2_r[SW-1];
    end
  end

  assign bnd = s2_r[SW-1] & ~enc_d_r;
  assign smp1 = s2_r[SMP_W-1:0];
  assign smp2 = s2_r[2*SMP_W-1:SMP_W];

  // bus slave: zero wait states, read data registered in the address phase
  aof_cfg_t cfg_r, cfg_nxt;
  logic dph_wr_r, dph_wr_nxt;
  logic [7:0] dph_addr_r, dph_addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic aph;
  aof_cfg_t act_r, act_nxt;
  logic [15:0] per_r, per_nxt;

  assign aph = I_HSEL & I_HTRANS[1] & I_HREADY;

  always_comb begin
    cfg_nxt = cfg_r;
    dph_wr_nxt = 1'b0;
    dph_addr_nxt = dph_addr_r;
    rdata_nxt = rdata_r;
    if (dph_wr_r) begin
      case (dph_addr_r)
        ADDR_CLK_CFG: begin
          cfg_nxt.phase = I_HWDATA[CLK_PH_LSB +: 2];
          cfg_nxt.invert = I_HWDATA[CLK_INV_BIT];
          cfg_nxt.dcs = I_HWDATA[CLK_DCS_BIT];
        end
        ADDR_DRV_CFG: begin
          cfg_nxt.mode = I_HWDATA[DRV_MODE_LSB +: 2];
          cfg_nxt.term = I_HWDATA[DRV_TERM_BIT];
          cfg_nxt.cur = I_HWDATA[DRV_CUR_LSB +: 3];
        end
        ADDR_FMT_CFG: begin
          cfg_nxt.twos = I_HWDATA[FMT_TWOS_BIT];
          cfg_nxt.rnd_en = I_HWDATA[FMT_RND_BIT];
          cfg_nxt.abp = I_HWDATA[FMT_ABP_BIT];
          cfg_nxt.tp = I_HWDATA[FMT_TP_LSB +: 3];
        end
        default: ;
      endcase
    end
    if (aph) begin
      dph_wr_nxt = I_HWRITE;
      dph_addr_nxt = (I_HADDR[31:8] == 24'h000000) ? I_HADDR[7:0] : ADDR_NONE;
      rdata_nxt = I_HWRITE ? 32'h00000000 : reg_read(dph_addr_nxt, cfg_nxt, act_r, per_r);
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      cfg_r <= CFG_RESET;
      dph_wr_r <= 1'b0;
      dph_addr_r <= ADDR_NONE;
      rdata_r <= '0;
    end else if (I_CE) begin
      cfg_r <= cfg_nxt;
      dph_wr_r <= dph_wr_nxt;
      dph_addr_r <= dph_addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign O_HRDATA = rdata_r;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;

  // sample timing, formatting and output multiplexing
  aof_word_t f1, f2, w1_r, w1_nxt, w2_r, w2_nxt;
  logic alt_r, alt_nxt;
  logic [15:0] cnt_r, cnt_nxt, meas, half, sh, pos;
  logic [15:0] fr1_r, fr1_nxt, fr2_r, fr2_nxt;
  logic fo1_r, fo1_nxt, fo2_r, fo2_nxt;
  logic [7:0] dd1_r, dd1_nxt, dd2_r, dd2_nxt;
  logic so_r, so_nxt, clkp_r, clkp_nxt;
  logic clkn_r, clkn_nxt;
  logic mid;

  aof_word_fmt u_fmt1 (.i_smp(smp1), .i_cfg(cfg_r), .i_alt(alt_r), .o_word(f1));
  aof_word_fmt u_fmt2 (.i_smp(smp2), .i_cfg(cfg_r), .i_alt(alt_r), .o_word(f2));

  always_comb begin
    act_nxt = act_r;
    per_nxt = per_r;
    alt_nxt = alt_r;
    w1_nxt = w1_r;
    w2_nxt = w2_r;
    fr1_nxt = fr1_r;
    fr2_nxt = fr2_r;
    fo1_nxt = fo1_r;
    fo2_nxt = fo2_r;
    dd1_nxt = dd1_r;
    dd2_nxt = dd2_r;
    so_nxt = so_r;
    meas = cnt_r + 16'h0001;
    cnt_nxt = (cnt_r == 16'hFFFF) ? cnt_r : meas;
    if (bnd) begin
      cnt_nxt = '0;
      per_nxt = (meas < MIN_PER) ? per_r : meas;
      act_nxt = cfg_r;
      alt_nxt = ~alt_r;
      w1_nxt = f1;
      w2_nxt = f2;
      if (is_ddr(cfg_r.mode)) begin
        fr1_nxt = '0;
        fr2_nxt = '0;
        fo1_nxt = 1'b0;
        fo2_nxt = 1'b0;
        dd1_nxt = pick(f1.data, 1'b0);
        dd2_nxt = pick(f2.data, 1'b0);
        so_nxt = f1.ovf;
      end else begin
        fr1_nxt = f1.data;
        fr2_nxt = f2.data;
        fo1_nxt = f1.ovf;
        fo2_nxt = f2.ovf;
        dd1_nxt = '0;
        dd2_nxt = '0;
        so_nxt = 1'b0;
      end
    end
    half = per_nxt >> 1;
    mid = !bnd && is_ddr(act_r.mode) && (cnt_nxt == half);
    if (mid) begin
      dd1_nxt = pick(w1_r.data, 1'b1);
      dd2_nxt = pick(w2_r.data, 1'b1);
      so_nxt = w2_r.ovf;
    end
    // clock falls at the boundary, rises at half period, delayed by phase/8
    sh = ph_shift(per_nxt, act_nxt.phase);
    pos = (cnt_nxt >= sh) ? cnt_nxt - sh : cnt_nxt + per_nxt - sh;
    clkp_nxt = (pos >= half) ^ act_nxt.invert;
    clkn_nxt = ~clkp_nxt;
  end

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      act_r <= CFG_RESET;
      per_r <= 16'(ENC_DIV);
      alt_r <= 1'b0;
      cnt_r <= '0;
      w1_r <= '0;
      w2_r <= '0;
      fr1_r <= '0;
      fr2_r <= '0;
      fo1_r <= 1'b0;
      fo2_r <= 1'b0;
      dd1_r <= '0;
      dd2_r <= '0;
      so_r <= 1'b0;
      clkp_r <= 1'b0;
      clkn_r <= 1'b1;
    end else if (I_CE) begin
      act_r <= act_nxt;
      per_r <= per_nxt;
      alt_r <= alt_nxt;
      cnt_r <= cnt_nxt;
      w1_r <= w1_nxt;
      w2_r <= w2_nxt;
      fr1_r <= fr1_nxt;
      fr2_r <= fr2_nxt;
      fo1_r <= fo1_nxt;
      fo2_r <= fo2_nxt;
      dd1_r <= dd1_nxt;
      dd2_r <= dd2_nxt;
      so_r <= so_nxt;
      clkp_r <= clkp_nxt;
      clkn_r <= clkn_nxt;
    end
  end

  assign O_CH1_SAMPLE_BITS = fr1_r;
  assign O_CH2_SAMPLE_BITS = fr2_r;
  assign O_CHAN1_OVERFLOW_OUT = fo1_r;
  assign O_CHAN2_OVERFLOW_OUT = fo2_r;
  assign O_CH1_DDR_BITS = dd1_r;
  assign O_CH2_DDR_BITS = dd2_r;
  assign O_SHARED_OVERFLOW_OUT = so_r;
  assign O_FWD_CLOCK_P = clkp_r;
  assign O_FWD_CLOCK_N = clkn_r;
  assign O_OUT_MODE = act_r.mode;
  assign O_TERM_EN = act_r.term;
  assign O_DRIVE_DOUBLE = act_r.term;
  assign O_DRIVE_CODE = act_r.cur;
  assign O_DCS_EN = act_r.dcs;

  // helper state read only by the checks below
  logic upd_r, prev_alt_r;
  logic [16:0] prev_out_r;

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      upd_r <= 1'b0;
      prev_alt_r <= 1'b0;
      prev_out_r <= '0;
    end else begin
      upd_r <= bnd & I_CE;
      if (upd_r) begin
        prev_alt_r <= (act_r.tp == TP_ALT) && (act_r.mode == MODE_FULL);
        prev_out_r <= {fo1_r, fr1_r};
      end
    end
  end

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);

  sequence s_fr_upd;
    upd_r && act_r.mode == MODE_FULL;
  endsequence

  sequence s_ddr_upd;
    upd_r && is_ddr(act_r.mode);
  endsequence

  AST_OVF_FLAG: assert property (
    cfg_r.tp == TP_NONE |-> f1.ovf == (smp1.over || smp1.under))
    else $error("overflow flag does not follow range error");
  AST_OVR_MAX: assert property (
    (cfg_r.tp == TP_NONE && !cfg_r.twos && !cfg_r.rnd_en && !cfg_r.abp && smp1.over)
    |-> f1.data == DATA_ONES)
    else $error("over range did not give maximum code");
  AST_MID_ZERO: assert property (
    (cfg_r.tp == TP_NONE && cfg_r.twos && !cfg_r.rnd_en && !cfg_r.abp &&
     !smp1.over && !smp1.under && smp1.code == MID_CODE) |-> f1.data == 16'h0000)
    else $error("mid code not zero in two's complement");
  AST_RAND_LSB: assert property (
    (cfg_r.tp == TP_NONE && cfg_r.rnd_en && !cfg_r.abp && !cfg_r.twos &&
     !smp1.over && !smp1.under)
    |-> f1.data == (smp1.code ^ {{15{smp1.code[0]}}, 1'b0}))
    else $error("randomizer output wrong");
  AST_ABP_ODD: assert property (
    (cfg_r.tp == TP_NONE && cfg_r.abp && !cfg_r.rnd_en && !cfg_r.twos &&
     !smp1.over && !smp1.under) |-> f1.data == (smp1.code ^ ABP_MASK))
    else $error("alternate polarity output wrong");
  AST_TP_ONES: assert property (
    cfg_r.tp == TP_ONES |-> f1 == 17'h1FFFF && f2 == 17'h1FFFF)
    else $error("all ones pattern not forced");
  AST_ALT_TOGGLE: assert property (
    (s_fr_upd and (act_r.tp == TP_ALT && prev_alt_r))
    |-> {fo1_r, fr1_r} == ~prev_out_r)
    else $error("alternating pattern did not toggle");
  AST_FALL_ALIGN: assert property (
    (s_fr_upd and (act_r.phase == 2'h0 && !act_r.invert))
    |-> !O_FWD_CLOCK_P && O_FWD_CLOCK_N)
    else $error("data change not at true clock falling edge");
  AST_DDR_SHARED: assert property (
    s_ddr_upd |-> O_SHARED_OVERFLOW_OUT == w1_r.ovf && !O_CHAN1_OVERFLOW_OUT)
    else $error("shared overflow wrong in DDR");
  AST_DDR_MID: assert property (
    (I_CE && mid) |=> O_CH1_DDR_BITS == pick(w1_r.data, 1'b1))
    else $error("second DDR half missing odd bits");
  AST_CFG_HOLD: assert property (
    !(bnd && I_CE) |=> $stable(act_r))
    else $error("applied settings changed between samples");
  AST_TERM_DBL: assert property (
    (bnd && I_CE) |=> O_DRIVE_DOUBLE == $past(cfg_r.term) && O_TERM_EN == O_DRIVE_DOUBLE)
    else $error("termination without doubled current");
endmodule

/* design/aof_pkg.sv */
package aof_pkg;
  localparam int DATA_W = 16;
  localparam int HALF_W = DATA_W / 2;
  // register byte offsets
  localparam logic [7:0] ADDR_CLK_CFG = 8'h08;
  localparam logic [7:0] ADDR_DRV_CFG = 8'h0C;
  localparam logic [7:0] ADDR_FMT_CFG = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_NONE = 8'hFF;
  // clock_config_reg fields
  localparam int CLK_PH_LSB = 0;
  localparam int CLK_INV_BIT = 2;
  localparam int CLK_DCS_BIT = 3;
  // output_drive_config_reg fields
  localparam int DRV_MODE_LSB = 0;
  localparam int DRV_TERM_BIT = 2;
  localparam int DRV_CUR_LSB = 3;
  // data_format_config_reg fields
  localparam int FMT_TWOS_BIT = 0;
  localparam int FMT_RND_BIT = 1;
  localparam int FMT_ABP_BIT = 2;
  localparam int FMT_TP_LSB = 3;
  // status fields
  localparam int STAT_PER_LSB = 0;
  localparam int STAT_MODE_LSB = 16;
  localparam int STAT_WARN_BIT = 18;
  // reset values and patterns
  localparam logic [2:0] CUR_DEFAULT = 3'h4;
  localparam logic [15:0] DATA_ONES = 16'hFFFF;
  localparam logic [15:0] MID_CODE = 16'h8000;
  localparam logic [15:0] ABP_MASK = 16'hAAAA;
  localparam logic [16:0] CHECKER = 17'h15555;
  localparam logic [15:0] MIN_PER = 16'h0004;
  // timing
  localparam int MCLK_PERIOD_NS = 10;
  localparam int ENC_PERIOD_NS = 160;
  localparam int ENC_DIV_DEFAULT = ENC_PERIOD_NS / MCLK_PERIOD_NS;
  localparam int PH_SHIFT_BITS = 3;

  typedef enum logic [1:0] {
    MODE_FULL = 2'b00,
    MODE_DDR_CMOS = 2'b01,
    MODE_DDR_LVDS = 2'b10
  } aof_mode_t;

  typedef enum logic [2:0] {
    TP_NONE = 3'b000,
    TP_ONES = 3'b001,
    TP_ZEROS = 3'b010,
    TP_ALT = 3'b011,
    TP_CHECK = 3'b100
  } aof_tp_t;

  typedef struct packed {
    logic [1:0] phase;
    logic invert;
    logic dcs;
    logic [1:0] mode;
    logic term;
    logic [2:0] cur;
    logic twos;
    logic rnd_en;
    logic abp;
    logic [2:0] tp;
  } aof_cfg_t;

  typedef struct packed {
    logic over;
    logic under;
    logic [15:0] code;
  } aof_sample_t;

  typedef struct packed {
    logic ovf;
    logic [15:0] data;
  } aof_word_t;

  localparam aof_cfg_t CFG_RESET = '{phase: 2'h0, invert: 1'b0, dcs: 1'b0,
    mode: MODE_FULL, term: 1'b0, cur: CUR_DEFAULT, twos: 1'b0, rnd_en: 1'b0,
    abp: 1'b0, tp: TP_NONE};
endpackage

/* design/aof_word_fmt.sv */
module aof_word_fmt
  import aof_pkg::*;
(
  input wire aof_sample_t i_smp,
  input wire aof_cfg_t i_cfg,
  input wire logic i_alt,
  output aof_word_t o_word
);
  logic [15:0] d;

  always_comb begin
    d = i_smp.code;
    if (i_smp.over) begin
      d = DATA_ONES;
    end else if (i_smp.under) begin
      d = '0;
    end
    // coding, then randomizer, then alternate polarity
    if (i_cfg.twos) begin
      d[15] = ~d[15];
    end
    if (i_cfg.rnd_en) begin
      d[15:1] = d[15:1] ^ {15{d[0]}};
    end
    if (i_cfg.abp) begin
      d = d ^ ABP_MASK;
    end
    o_word.ovf = i_smp.over | i_smp.under;
    o_word.data = d;
    // a selected test pattern replaces the formatted word
    case (i_cfg.tp)
      TP_ONES: o_word = '1;
      TP_ZEROS: o_word = '0;
      TP_ALT: o_word = {17{~i_alt}};
      TP_CHECK: o_word = CHECKER ^ {17{i_alt}};
      default: ;
    endcase
  end
endmodule

/* verification/aof_rx_model.sv */
module aof_rx_model
  import aof_pkg::*;
(
  input wire logic i_fwd_clock_p,
  input wire logic [15:0] i_bits,
  input wire logic i_ovf,
  input wire logic i_rnd,
  input wire logic i_abp,
  output aof_word_t o_word
);
  timeunit 1ns;
  timeprecision 1ps;
  aof_word_t cap;
  logic [15:0] d1;
  initial cap = '0;
  always @(posedge i_fwd_clock_p) cap <= '{ovf: i_ovf, data: i_bits};
  // undo polarity first, then the randomizer
  always_comb begin
    d1 = i_abp ? cap.data ^ ABP_MASK : cap.data;
    o_word.ovf = cap.ovf;
    o_word.data = i_rnd ? d1 ^ {{15{d1[0]}}, 1'b0} : d1;
  end
endmodule

/* verification/tb_adc_output_formatter.sv */
module tb_adc_output_formatter
  import aof_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = ENC_PERIOD_NS / MCLK_PERIOD_NS;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic enc = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  aof_sample_t s1 = '0;
  aof_sample_t s2 = '0;
  logic rnd = 1'b0;
  logic abp = 1'b0;
  logic [31:0] hrdata;
  logic hready, hresp, f1, f2, fs, ckp, ckn, term, dbl, dcs;
  logic [15:0] b1, b2;
  logic [7:0] d1, d2;
  logic [1:0] omode;
  logic [2:0] dcode;
  aof_word_t rx;
  int n_fail = 0;
  int checks_done = 0;
  aof_sample_t tab[4] = '{'{1'b0, 1'b0, MID_CODE}, '{1'b0, 1'b0, 16'h1235},
    '{1'b1, 1'b0, 16'h1234}, '{1'b0, 1'b1, 16'h4321}};

  always #5 clk = ~clk;
  initial begin
    forever begin
      repeat (P / 2) @(posedge clk);
      enc <= ~enc;
    end
  end

  aof_top #(.ENC_DIV(P)) DUT (.I_MCLK(clk), .I_RESET(rst), .I_CE(ce), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
    .I_HREADY(hready), .I_HWDATA(hwdata), .O_HRDATA(hrdata), .O_HREADYOUT(hready),
    .O_HRESP(hresp), .I_ENC_CLK(enc), .I_CH1_CODE(s1.code), .I_CH1_OVER(s1.over),
    .I_CH1_UNDER(s1.under), .I_CH2_CODE(s2.code), .I_CH2_OVER(s2.over),
    .I_CH2_UNDER(s2.under), .O_CH1_SAMPLE_BITS(b1), .O_CH2_SAMPLE_BITS(b2),
    .O_CHAN1_OVERFLOW_OUT(f1), .O_CHAN2_OVERFLOW_OUT(f2), .O_CH1_DDR_BITS(d1),
    .O_CH2_DDR_BITS(d2), .O_SHARED_OVERFLOW_OUT(fs), .O_FWD_CLOCK_P(ckp),
    .O_FWD_CLOCK_N(ckn), .O_OUT_MODE(omode), .O_TERM_EN(term), .O_DRIVE_DOUBLE(dbl),
    .O_DRIVE_CODE(dcode), .O_DCS_EN(dcs));

  aof_rx_model rx_model (.i_fwd_clock_p(ckp), .i_bits(b1), .i_ovf(f1), .i_rnd(rnd),
    .i_abp(abp), .o_word(rx));

  task automatic complete_run;
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  // lands in the first half of a sample, clear of both update points
  task automatic smp(input int n);
    repeat (n) @(posedge enc);
    repeat (7) @(posedge clk);
    #1;
  endtask

  function automatic logic [16:0] fmt(aof_sample_t s, logic [2:0] f);
    logic [15:0] d;
    d = s.over ? DATA_ONES : (s.under ? 16'h0000 : s.code);
    if (f[0]) d[15] = ~d[15];
    if (f[1]) d = d ^ {{15{d[0]}}, 1'b0};
    if (f[2]) d = d ^ ABP_MASK;
    return {s.over | s.under, d};
  endfunction

  initial begin
    logic [16:0] e, e2, prev, base;
    logic [7:0] ev, od, ev2, od2;
    logic last, tgt, ok;
    int n;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({b1, f1, ckp, ckn, dcode, hresp}, {17'h0, 2'b01, CUR_DEFAULT, 1'b0});
    rd_chk(ADDR_DRV_CFG, {26'h0, CUR_DEFAULT, 3'h0});
    rd_chk(ADDR_FMT_CFG, 32'h0);
    rd_chk(8'h20, 32'h0);
    for (int f = 0; f < 8; f++) begin
      for (int i = 0; i < 4; i++) begin
        wr(ADDR_FMT_CFG, f);
        rnd <= f[1];
        abp <= f[2];
        s1 <= tab[i];
        s2 <= tab[3 - i];
        smp(3);
        chk({f1, b1}, fmt(tab[i], f[2:0]));
        chk({f2, b2}, fmt(tab[3 - i], f[2:0]));
        repeat (8) @(posedge clk);
        #1;
        chk(rx, fmt(tab[i], {2'b00, f[0]}));
      end
    end
    rd_chk(ADDR_FMT_CFG, 32'h7);
    wr(ADDR_DRV_CFG, 32'h24);
    smp(2);
    chk({term, dbl, dcode}, {2'b11, CUR_DEFAULT});
    for (int tp = 1; tp < 5; tp++) begin
      wr(ADDR_FMT_CFG, {26'h0, tp[2:0], 3'h7});
      smp(3);
      prev = {f1, b1};
      smp(1);
      e = {f1, b1};
      base = (tp == TP_CHECK) ? CHECKER : 17'h1FFFF;
      ok = (tp == TP_ONES) ? (e === base) : (tp == TP_ZEROS) ? (e === ~base)
           : (e === base || e === ~base);
      chk({31'h0, ok}, 32'h1);
      chk(e ^ prev, (tp > 2) ? 17'h1FFFF : 17'h0);
    end
    wr(ADDR_FMT_CFG, {26'h0, TP_ALT, 3'h0});
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CLK_CFG, {28'h0, 1'b1, c[2], c[1:0]});
      smp(2);
      prev = {f1, b1};
      n = 0;
      while ({f1, b1} === prev && n < 40) begin
        @(posedge clk);
        #1;
        n++;
      end
      tgt = ~c[2];
      n = 0;
      do begin
        last = ckp;
        @(posedge clk);
        #1;
        n++;
      end while (!(ckp === tgt && last !== tgt) && n < 40);
      chk(n, P / 2 + P * c[1:0] / 8);
      chk({dcs, ckn}, {1'b1, ~ckp});
    end
    wr(ADDR_CLK_CFG, 32'h0);
    wr(ADDR_FMT_CFG, 32'h0);
    for (int m = 1; m < 3; m++) begin
      wr(ADDR_DRV_CFG, {26'h0, CUR_DEFAULT, 1'b0, m[1:0]});
      s1 <= tab[1];
      s2 <= tab[2];
      smp(3);
      e = fmt(tab[1], 3'h0);
      e2 = fmt(tab[2], 3'h0);
      for (int b = 0; b < 8; b++) begin
        ev[b] = e[2 * b];
        od[b] = e[2 * b + 1];
        ev2[b] = e2[2 * b];
        od2[b] = e2[2 * b + 1];
      end
      chk({fs, d1, b1, f1, omode}, {e[16], ev, 17'h0, m[1:0]});
      chk({d2, b2, f2}, {ev2, 17'h0});
      repeat (8) @(posedge clk);
      #1;
      chk({fs, d1}, {e2[16], od});
      chk(d2, od2);
      rd_chk(ADDR_STATUS, {13'h0, 1'b0, m[1:0], 16'(P)});
    end
    // clock enable low must freeze the forwarded clock and the outputs
    ce <= 1'b0;
    @(posedge clk);
    #1;
    e = {7'h0, ckp, fs, d1};
    repeat (20) @(posedge clk);
    #1;
    chk({ckp, fs, d1}, e[9:0]);
    @(posedge clk);
    ce <= 1'b1;
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule
